/* File: verilog/strap_pkg.sv */
package strap_pkg;

  // Management register addresses
  localparam logic [4:0] ADDR_CTRL      = 5'h00;
  localparam logic [4:0] ADDR_STATUS    = 5'h01;
  localparam logic [4:0] ADDR_ID_HIGH   = 5'h02;
  localparam logic [4:0] ADDR_ID_LOW    = 5'h03;
  localparam logic [4:0] ADDR_ADV       = 5'h04;
  localparam logic [4:0] ADDR_PARTNER   = 5'h05;
  localparam logic [4:0] ADDR_EXPANSION = 5'h06;
  localparam logic [4:0] ADDR_CFG_INFO  = 5'h11;
  localparam logic [4:0] ADDR_INT_EN    = 5'h12;
  localparam logic [4:0] ADDR_FAST_CTRL = 5'h13;
  localparam logic [4:0] ADDR_MODE_CTRL = 5'h14;
  localparam int         VENDOR_REGS    = 4;

  // Control register bit positions
  localparam int CTRL_RESET_BIT   = 15;
  localparam int CTRL_LOOP_BIT    = 14;
  localparam int CTRL_SPEED_BIT   = 13;
  localparam int CTRL_AUTONEG_ENABLE_BIT_BIT    = 12;
  localparam int CTRL_PDOWN_BIT   = 11;
  localparam int CTRL_ISO_BIT     = 10;
  localparam int CTRL_RESTART_BIT = 9;
  localparam int CTRL_DUPLEX_BIT  = 8;
  localparam int CTRL_COLL_BIT    = 7;

  // Control register values after reset
  localparam logic CTRL_LOOP_RST   = 1'h0;
  localparam logic CTRL_SPEED_RST  = 1'h1;
  localparam logic CTRL_AUTONEG_ENABLE_BIT_RST   = 1'h1;
  localparam logic CTRL_DUPLEX_RST = 1'h0;

  // Advertisement field: bits 8..5, selector in 4..0
  localparam int         ADV_LSB         = 5;
  localparam int         ADV_MSB         = 8;
  localparam logic [3:0] ADV_DEFAULT     = 4'hF;
  localparam logic [4:0] ADV_SELECTOR    = 5'h01;

  // Read-only words; identifier values are arbitrary
  localparam logic [15:0] STATUS_VALUE = 16'h7800;
  localparam logic [15:0] PHY_ID_HIGH  = 16'h1234;
  localparam logic [15:0] PHY_ID_LOW   = 16'h5670;

  // Sequencing counts in clk_sys cycles or management bits
  localparam logic [4:0] SOFT_RESET_LAST = 5'h0F;
  localparam logic [5:0] PREAMBLE_BITS   = 6'h20;
  localparam logic [4:0] HEADER_LAST     = 5'h0C;
  localparam logic [4:0] TURN_LAST       = 5'h01;
  localparam logic [4:0] DATA_LAST       = 5'h0F;
  localparam logic [1:0] OP_READ         = 2'h2;
  localparam logic [1:0] OP_WRITE        = 2'h1;

  typedef enum logic [1:0] {
    MD_PREAMBLE = 2'h0,
    MD_HEADER   = 2'h1,
    MD_TURN     = 2'h3,
    MD_DATA     = 2'h2
  } mdio_state_e;

  typedef enum logic [1:0] {
    RS_LOAD = 2'h0,
    RS_RUN  = 2'h1,
    RS_SOFT = 2'h3
  } reset_state_e;

endpackage

/* File: verilog/mgmt_if.sv */
interface mgmt_if;
  logic        wr_stb;
  logic [4:0]  addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic [4:0]  phy_addr;

  modport serial_end (output wr_stb, addr, wdata, input rdata, phy_addr);
  modport regs_end   (input wr_stb, addr, wdata, output rdata, phy_addr);
endinterface

/* File: verilog/mdio_serial_slave.sv */
module mdio_serial_slave (
  // Clock and reset
  input  logic       clk_sys,
  input  logic       rst_b,
  // Management pins
  input  logic       mdc,
  input  logic       mdio_i,
  output logic       mdio_o,
  output logic       mdio_oe,
  // Register side
  mgmt_if.serial_end regs
);

  strap_pkg::mdio_state_e st_q;
  logic                   mdc_q;
  logic                   rise;
  logic [5:0]             ones_q;
  logic [4:0]             cnt_q;
  logic [11:0]            hdr_q;
  logic [12:0]            hdr_w;
  logic [15:0]            shift_q;
  logic                   rd_q;
  logic                   hit;

  // Edge of the management clock, seen in clk_sys
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mdc_q <= 1'b0;
    end else begin
      mdc_q <= mdc;
    end
  end

  assign rise  = mdc & ~mdc_q;
  assign hdr_w = {hdr_q, mdio_i};
  // Only frames for our own address go further
  assign hit = hdr_w[12] && (hdr_w[9:5] == regs.phy_addr) &&
               ((hdr_w[11:10] == strap_pkg::OP_READ) ||
                (hdr_w[11:10] == strap_pkg::OP_WRITE));

  // Frame sequencer; a fresh preamble is needed before every frame
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_q      <= strap_pkg::MD_PREAMBLE;
      ones_q    <= 6'h00;
      cnt_q     <= 5'h00;
      hdr_q     <= 12'h000;
      rd_q      <= 1'b0;
      regs.addr <= 5'h00;
    end else if (rise) begin
      unique case (st_q)
        strap_pkg::MD_PREAMBLE: begin
          if (mdio_i) begin
            if (ones_q != strap_pkg::PREAMBLE_BITS) begin
              ones_q <= ones_q + 6'h01;
            end
          end else if (ones_q == strap_pkg::PREAMBLE_BITS) begin
            st_q  <= strap_pkg::MD_HEADER;
            cnt_q <= 5'h00;
          end else begin
            ones_q <= 6'h00;
          end
        end
        strap_pkg::MD_HEADER: begin
          hdr_q <= hdr_w[11:0];
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q == strap_pkg::HEADER_LAST) begin
            ones_q <= 6'h00;
            cnt_q  <= 5'h00;
            if (hit) begin
              st_q      <= strap_pkg::MD_TURN;
              rd_q      <= (hdr_w[11:10] == strap_pkg::OP_READ);
              regs.addr <= hdr_w[4:0];
            end else begin
              st_q <= strap_pkg::MD_PREAMBLE;
            end
          end
        end
        strap_pkg::MD_TURN: begin
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q == strap_pkg::TURN_LAST) begin
            st_q  <= strap_pkg::MD_DATA;
            cnt_q <= 5'h00;
          end
        end
        strap_pkg::MD_DATA: begin
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q == strap_pkg::DATA_LAST) begin
            st_q <= strap_pkg::MD_PREAMBLE;
          end
        end
      endcase
    end
  end

  // Data shifting, pin drive and write strobe
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      shift_q     <= 16'h0000;
      mdio_o      <= 1'b0;
      mdio_oe     <= 1'b0;
      regs.wr_stb <= 1'b0;
      regs.wdata  <= 16'h0000;
    end else begin
      regs.wr_stb <= 1'b0;
      if (rise && st_q == strap_pkg::MD_TURN && rd_q) begin
        mdio_oe <= 1'b1; // Second turnaround bit is driven low
        if (cnt_q == 5'h00) begin
          mdio_o <= 1'b0;
        end else begin
          shift_q <= regs.rdata;
          mdio_o  <= regs.rdata[15];
        end
      end else if (rise && st_q == strap_pkg::MD_DATA && rd_q) begin
        if (cnt_q == strap_pkg::DATA_LAST) begin
          mdio_oe <= 1'b0;
        end else begin
          mdio_o  <= shift_q[14];
          shift_q <= {shift_q[14:0], 1'b0};
        end
      end else if (rise && st_q == strap_pkg::MD_DATA) begin
        shift_q <= {shift_q[14:0], mdio_i};
        if (cnt_q == strap_pkg::DATA_LAST) begin
          regs.wr_stb <= 1'b1;
          regs.wdata  <= {shift_q[14:0], mdio_i};
        end
      end
    end
  end

endmodule // mdio_serial_slave

/* File: verilog/phy_strap_config_and_control_regs.sv */
// Contract
// - Registers load from straps at reset; afterwards only management writes change them.
// - Advertised 100 full is first config AND duplex strap; 100 half is first config.
// - Advertised 10 full is second config AND duplex strap; 10 half is second config.
// - Without negotiation enabled, advertisement bits 5..8 keep their default value.
// - Negotiation enable bit starts from multifunction strap zero.
// - Address pin low at reset gives active-high LED, high gives active-low.
// - Five sampled address pins form the address; only matching frames are answered.
// - All-zero sampled address sets the isolate bit at reset.
// - Eleven 16-bit registers: addresses 0 to 6 and 17 to 20.
// - Control bit 15 written one resets the device, clears when done, reads 0.
// - Control bit 14 selects loopback, default zero.
// - Control bit 13 selects 100 Mb/s, default one, ignored while negotiating.
// - Control bit 12 enables negotiation, default one.
// - Without negotiation, duplex bit 8 copies the full-duplex strap.
// - Speed bit starts from multifunction strap four.
// - Isolate ignores transmit inputs and floats MII outputs; management still works.
module phy_strap_config_and_control_regs (
  // Clock and reset
  input  logic       clk_sys,
  input  logic       rst_b,
  // Serial management pins
  input  logic       mdc,
  input  logic       mdio_i,
  output logic       mdio_o,
  output logic       mdio_oe,
  // Configuration straps
  input  logic [4:0] multifunction_straps,
  input  logic       config_strap_first,
  input  logic       config_strap_second,
  input  logic       full_duplex_strap,
  // Shared LED and address pins
  input  logic [4:0] led_pad_i,
  output logic [4:0] led_pad_o_q,
  output logic [4:0] led_pad_oe_q,
  input  logic [4:0] led_status,
  // MAC transmit side
  input  logic       mac_tx_en,
  input  logic       mac_tx_er,
  input  logic [3:0] mac_txd,
  output logic       tx_en_q,
  output logic       tx_er_q,
  output logic [3:0] txd_q,
  output logic       mii_out_oe_q,
  // Mode outputs to the datapath
  output logic       core_reset_q,
  output logic       loopback_q,
  output logic       autoneg_en_q,
  output logic       forced_speed_100_q,
  output logic       forced_full_duplex_q,
  output logic       restart_an_q,
  output logic       power_down_q,
  output logic       coll_test_q,
  output logic       isolate_q,
  output logic [3:0] adv_abilities_q
);

  // Upper bound for the soft reset check, above the 16-cycle sequence
  localparam int SOFT_BOUND = 20;

  mgmt_if regs ();

  strap_pkg::reset_state_e rs_q;
  logic [4:0]              sr_cnt_q;
  logic [4:0]              pad_q;
  logic                    speed_q;
  logic                    duplex_q;
  logic                    load;
  logic                    ctrl_wr;
  logic                    adv_wr;
  logic [15:0]             ctrl_word;
  logic [15:0]             vend_q [strap_pkg::VENDOR_REGS];

  // Address decode used only by the unmapped-read check
  function automatic logic is_mapped(input logic [4:0] a);
    is_mapped = (a <= strap_pkg::ADDR_EXPANSION) ||
                ((a >= strap_pkg::ADDR_CFG_INFO) &&
                 (a <= strap_pkg::ADDR_MODE_CTRL));
  endfunction

  // Strap view of the advertisement field, bits 8 down to 5
  function automatic logic [3:0] adv_from_straps(input logic c0,
                                                 input logic c1,
                                                 input logic fd);
    adv_from_straps = {c0 & fd, c0, c1 & fd, c1};
  endfunction

  mdio_serial_slave u_serial (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .mdc     (mdc),
    .mdio_i  (mdio_i),
    .mdio_o  (mdio_o),
    .mdio_oe (mdio_oe),
    .regs    (regs.serial_end)
  );

  // Writes are only taken while running, so a load is never overridden
  assign load    = (rs_q == strap_pkg::RS_LOAD);
  assign ctrl_wr = regs.wr_stb && (regs.addr == strap_pkg::ADDR_CTRL) &&
                   (rs_q == strap_pkg::RS_RUN);
  assign adv_wr  = regs.wr_stb && (regs.addr == strap_pkg::ADDR_ADV) &&
                   (rs_q == strap_pkg::RS_RUN);
  assign regs.phy_addr = pad_q;

  // Reset sequencer: load straps, run, soft reset, load again
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rs_q     <= strap_pkg::RS_LOAD;
      sr_cnt_q <= 5'h00;
    end else begin
      unique case (rs_q)
        strap_pkg::RS_LOAD: begin
          rs_q <= strap_pkg::RS_RUN;
        end
        strap_pkg::RS_RUN: begin
          if (ctrl_wr && regs.wdata[strap_pkg::CTRL_RESET_BIT]) begin
            rs_q     <= strap_pkg::RS_SOFT;
            sr_cnt_q <= 5'h00;
          end
        end
        strap_pkg::RS_SOFT: begin
          if (sr_cnt_q == strap_pkg::SOFT_RESET_LAST) begin
            rs_q <= strap_pkg::RS_LOAD;
          end else begin
            sr_cnt_q <= sr_cnt_q + 5'h01;
          end
        end
        default: begin
          rs_q <= strap_pkg::RS_LOAD;
        end
      endcase
    end
  end

  // Address straps caught one edge after reset release, not under reset
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pad_q <= 5'h00;
    end else if (load) begin
      pad_q <= led_pad_i;
    end
  end

  // Control register fields
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      loopback_q   <= strap_pkg::CTRL_LOOP_RST;
      speed_q      <= strap_pkg::CTRL_SPEED_RST;
      autoneg_en_q <= strap_pkg::CTRL_AUTONEG_ENABLE_BIT_RST;
      power_down_q <= 1'b0;
      isolate_q    <= 1'b0;
      restart_an_q <= 1'b0;
      duplex_q     <= strap_pkg::CTRL_DUPLEX_RST;
      coll_test_q  <= 1'b0;
    end else if (load) begin
      loopback_q   <= strap_pkg::CTRL_LOOP_RST;
      speed_q      <= multifunction_straps[4];
      autoneg_en_q <= multifunction_straps[0];
      power_down_q <= 1'b0;
      isolate_q    <= (led_pad_i == 5'h00);
      restart_an_q <= 1'b0;
      // Strap only decides duplex when negotiation is off
      duplex_q     <= multifunction_straps[0] ? strap_pkg::CTRL_DUPLEX_RST
                                              : full_duplex_strap;
      coll_test_q  <= 1'b0;
    end else begin
      restart_an_q <= 1'b0; // Self-clearing, a one-cycle request
      if (ctrl_wr) begin
        loopback_q   <= regs.wdata[strap_pkg::CTRL_LOOP_BIT];
        speed_q      <= regs.wdata[strap_pkg::CTRL_SPEED_BIT];
        autoneg_en_q <= regs.wdata[strap_pkg::CTRL_AUTONEG_ENABLE_BIT_BIT];
        power_down_q <= regs.wdata[strap_pkg::CTRL_PDOWN_BIT];
        isolate_q    <= regs.wdata[strap_pkg::CTRL_ISO_BIT];
        restart_an_q <= regs.wdata[strap_pkg::CTRL_RESTART_BIT];
        duplex_q     <= regs.wdata[strap_pkg::CTRL_DUPLEX_BIT];
        coll_test_q  <= regs.wdata[strap_pkg::CTRL_COLL_BIT];
      end
    end
  end

  // Advertisement abilities, strap-derived only with negotiation on
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      adv_abilities_q <= strap_pkg::ADV_DEFAULT;
    end else if (load) begin
      if (multifunction_straps[0]) begin
        adv_abilities_q <= adv_from_straps(config_strap_first,
                                           config_strap_second,
                                           full_duplex_strap);
      end else begin
        adv_abilities_q <= strap_pkg::ADV_DEFAULT;
      end
    end else if (adv_wr) begin
      adv_abilities_q <= regs.wdata[strap_pkg::ADV_MSB:strap_pkg::ADV_LSB];
    end
  end

  // Vendor registers 17..20 are plain storage, cleared on every load
  for (genvar i = 0; i < strap_pkg::VENDOR_REGS; i++) begin : g_vendor
    always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
        vend_q[i] <= 16'h0000;
      end else if (load) begin
        vend_q[i] <= 16'h0000;
      end else if (regs.wr_stb && (rs_q == strap_pkg::RS_RUN) &&
                   (regs.addr == strap_pkg::ADDR_CFG_INFO + 5'(i))) begin
        vend_q[i] <= regs.wdata;
      end
    end
  end

  // Reset bit reads one until the sequence is back to running
  always_comb begin
    ctrl_word = 16'h0000;
    ctrl_word[strap_pkg::CTRL_RESET_BIT]   = (rs_q != strap_pkg::RS_RUN);
    ctrl_word[strap_pkg::CTRL_LOOP_BIT]    = loopback_q;
    ctrl_word[strap_pkg::CTRL_SPEED_BIT]   = speed_q;
    ctrl_word[strap_pkg::CTRL_AUTONEG_ENABLE_BIT_BIT]    = autoneg_en_q;
    ctrl_word[strap_pkg::CTRL_PDOWN_BIT]   = power_down_q;
    ctrl_word[strap_pkg::CTRL_ISO_BIT]     = isolate_q;
    ctrl_word[strap_pkg::CTRL_RESTART_BIT] = restart_an_q;
    ctrl_word[strap_pkg::CTRL_DUPLEX_BIT]  = duplex_q;
    ctrl_word[strap_pkg::CTRL_COLL_BIT]    = coll_test_q;
  end

  // Read multiplexer; unmapped addresses fall to zero
  always_comb begin
    regs.rdata = 16'h0000;
    case (regs.addr)
      strap_pkg::ADDR_CTRL: begin
        regs.rdata = ctrl_word;
      end
      strap_pkg::ADDR_STATUS: begin
        regs.rdata = strap_pkg::STATUS_VALUE;
      end
      strap_pkg::ADDR_ID_HIGH: begin
        regs.rdata = strap_pkg::PHY_ID_HIGH;
      end
      strap_pkg::ADDR_ID_LOW: begin
        regs.rdata = strap_pkg::PHY_ID_LOW;
      end
      strap_pkg::ADDR_ADV: begin
        regs.rdata[strap_pkg::ADV_MSB:strap_pkg::ADV_LSB] = adv_abilities_q;
        regs.rdata[4:0] = strap_pkg::ADV_SELECTOR;
      end
      strap_pkg::ADDR_CFG_INFO,
      strap_pkg::ADDR_INT_EN,
      strap_pkg::ADDR_FAST_CTRL,
      strap_pkg::ADDR_MODE_CTRL: begin
        regs.rdata = vend_q[2'(regs.addr - strap_pkg::ADDR_CFG_INFO)];
      end
      default: begin
        regs.rdata = 16'h0000;
      end
    endcase
  end

  // Pin side: isolate and power-down gate the MII, LEDs follow polarity
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tx_en_q              <= 1'b0;
      tx_er_q              <= 1'b0;
      txd_q                <= 4'h0;
      mii_out_oe_q         <= 1'b0;
      led_pad_o_q          <= 5'h00;
      led_pad_oe_q         <= 5'h00;
      core_reset_q         <= 1'b1;
      forced_speed_100_q   <= 1'b0;
      forced_full_duplex_q <= 1'b0;
    end else begin
      tx_en_q      <= mac_tx_en & ~isolate_q & ~power_down_q;
      tx_er_q      <= mac_tx_er & ~isolate_q & ~power_down_q;
      txd_q        <= (isolate_q | power_down_q) ? 4'h0 : mac_txd;
      mii_out_oe_q <= (rs_q == strap_pkg::RS_RUN) &
                      ~isolate_q & ~power_down_q;
      // Pins float while straps may be sampled so they read true
      led_pad_oe_q <= {5{(rs_q == strap_pkg::RS_RUN) & ~power_down_q}};
      led_pad_o_q  <= led_status ^ pad_q;
      core_reset_q <= (rs_q != strap_pkg::RS_RUN);
      forced_speed_100_q   <= speed_q & ~autoneg_en_q;
      forced_full_duplex_q <= duplex_q & ~autoneg_en_q;
    end
  end

  a_soft_reset_clear: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    (ctrl_wr && regs.wdata[strap_pkg::CTRL_RESET_BIT]) |=>
    ctrl_word[strap_pkg::CTRL_RESET_BIT] ##[1:SOFT_BOUND]
    (rs_q == strap_pkg::RS_RUN && !ctrl_word[strap_pkg::CTRL_RESET_BIT]))
    else $error("soft reset bit did not self-clear in time");

  a_autoneg_enable_bit_from_strap: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    load |=> (autoneg_en_q == $past(multifunction_straps[0])))
    else $error("negotiation enable not loaded from strap");

  a_speed_from_strap: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    load |=> (speed_q == $past(multifunction_straps[4])))
    else $error("speed bit not loaded from strap");

  a_adv_strap_load: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    (load && multifunction_straps[0]) |=>
    (adv_abilities_q == {$past(config_strap_first & full_duplex_strap),
                         $past(config_strap_first),
                         $past(config_strap_second & full_duplex_strap),
                         $past(config_strap_second)}))
    else $error("advertisement not derived from straps");

  a_adv_default_keep: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    (load && !multifunction_straps[0]) |=>
    (adv_abilities_q == strap_pkg::ADV_DEFAULT))
    else $error("advertisement changed with negotiation off");

  a_duplex_from_strap: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    (load && !multifunction_straps[0]) |=>
    (duplex_q == $past(full_duplex_strap)))
    else $error("duplex bit does not follow strap");

  a_isolate_zero_addr: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    load |=> (isolate_q == ($past(led_pad_i) == 5'h00)))
    else $error("isolate not set from zero address");

  a_isolate_gates_tx: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    isolate_q |=> (!tx_en_q && !tx_er_q && !mii_out_oe_q))
    else $error("isolated device still passes MII traffic");

  a_led_polarity: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    (rs_q == strap_pkg::RS_RUN) ##1 (rs_q == strap_pkg::RS_RUN) |->
    (led_pad_o_q == ($past(led_status) ^ pad_q)))
    else $error("LED polarity does not follow address strap");

  a_unmapped_reads_zero: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    !is_mapped(regs.addr) |-> (regs.rdata == 16'h0000))
    else $error("unmapped address read nonzero");

  a_speed_ignored_an: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    $rose(autoneg_en_q) |=> !forced_speed_100_q [*2])
    else $error("forced speed active while negotiating");

endmodule // phy_strap_config_and_control_regs

/* File: verification/mdio_master_model.sv */
module mdio_master_model (
  // Clock and management pins
  input  wire logic clk_sys,
  output logic      mdc,
  output logic      mdio_i,
  input  wire logic mdio_o,
  input  wire logic mdio_oe
);
  timeunit 1ns;
  timeprecision 100ps;

  logic drv;
  logic bit_q;

  // Pull-up wins when nobody drives, so a silent device reads as ones
  assign mdio_i = mdio_oe ? mdio_o : (drv ? bit_q : 1'h1);

  // Management clock stands low between frames
  initial begin
    mdc = 1'h0;
    drv = 1'h0;
    bit_q = 1'h1;
  end

  // One whole frame with its own preamble; reads let go at turnaround
  task automatic xfer(input logic [1:0] op, input logic [4:0] pa,
                      input logic [4:0] ra, input logic [15:0] wd,
                      output logic [15:0] rd);
    logic [63:0] f;
    f = {32'hFFFFFFFF, 2'h1, op, pa, ra, 2'h2, wd};
    rd = 16'h0000;
    for (int p = 0; p < 64; p++) begin
      if (p > 47) rd = {rd[14:0], mdio_i};
      drv = (op == 2'h1) || (p < 46);
      bit_q = f[63 - p];
      repeat (4) @(posedge clk_sys);
      #1 mdc = 1'h1;
      repeat (4) @(posedge clk_sys);
      #1 mdc = 1'h0;
    end
    repeat (8) @(posedge clk_sys);
    #1 drv = 1'h0;
    // One idle edge so a following frame never reassigns drv at once
    @(posedge clk_sys) #1;
  endtask
endmodule // mdio_master_model

/* File: verification/testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk_sys, rst_b, mdc, mdio_i, mdio_o, mdio_oe;
  logic [4:0]  mf, pad, led_pad_o_q, led_pad_oe_q, led_status;
  logic        cfg1st, cfg2nd, fds, mac_tx_en, mac_tx_er;
  logic [3:0]  mac_txd, txd_q, adv;
  logic        tx_en_q, tx_er_q, mii_oe, lb, autoneg_enable_bit;
  logic        iso, crst, fsp, ffd, col, pdn, rsa;
  logic [15:0] rd, seen, xa, xc;
  logic [15:0] v[4];
  logic [15:0] eq[$];
  string       nq[$];
  int          n_fail, cmp_count, cyc, n_rsa;
  event        got;

  phy_strap_config_and_control_regs phy_strap_config_and_control_regs_i (
    .clk_sys, .rst_b, .mdc, .mdio_i, .mdio_o, .mdio_oe,
    .multifunction_straps(mf), .config_strap_first(cfg1st),
    .config_strap_second(cfg2nd), .full_duplex_strap(fds),
    .led_pad_i(pad), .led_pad_o_q, .led_pad_oe_q, .led_status,
    .mac_tx_en, .mac_tx_er, .mac_txd, .tx_en_q, .tx_er_q, .txd_q,
    .mii_out_oe_q(mii_oe), .core_reset_q(crst), .loopback_q(lb),
    .autoneg_en_q(autoneg_enable_bit), .forced_speed_100_q(fsp),
    .forced_full_duplex_q(ffd), .restart_an_q(rsa), .power_down_q(pdn),
    .coll_test_q(col), .isolate_q(iso), .adv_abilities_q(adv));

  mdio_master_model mdio_master_model_i (.clk_sys, .mdc, .mdio_i,
    .mdio_o, .mdio_oe);

  // Free-running system clock
  initial begin
    clk_sys = 1'h0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // Hang guard, well above the expected run length
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      final_report();
    end
  end

  // Restart request is a one-cycle pulse, so count it as it passes
  always @(posedge clk_sys) begin
    if (rsa === 1'h1) n_rsa++;
  end

  // Oldest expectation against each result as it shows up
  always @(got) begin
    cmp_count++;
    if (seen !== eq[0]) begin
      n_fail++;
      $display("mismatch %s exp %h seen %h", nq[0], eq[0], seen);
    end
    void'(eq.pop_front());
    void'(nq.pop_front());
  end

  task automatic chk(input string n, input logic [15:0] e, s);
    nq.push_back(n);
    eq.push_back(e);
    seen = s;
    ->got;
    @(posedge clk_sys) #1;
  endtask

  task automatic rdc(input logic [4:0] ra, input logic [15:0] e, string n);
    mdio_master_model_i.xfer(2'h2, pad, ra, 16'h0000, rd);
    chk(n, e, rd);
  endtask

  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    mdio_master_model_i.xfer(2'h1, pad, ra, d, rd);
  endtask

  // Expected strap-derived control and advertisement words
  task automatic calc();
    xa = {7'h00, mf[0] ? {cfg1st & fds, cfg1st, cfg2nd & fds, cfg2nd}
          : strap_pkg::ADV_DEFAULT, strap_pkg::ADV_SELECTOR};
    xc = {2'h0, mf[4], mf[0], 1'h0, pad == 5'h00, 1'h0, ~mf[0] & fds, 8'h00};
  endtask

  // Straps are only meaningful at load, so they change under reset
  task automatic boot(input logic an, input logic [4:0] p);
    @(posedge clk_sys) #1 rst_b = 1'h0;
    {mf, cfg1st, cfg2nd, fds} = 8'($urandom);
    mf[0] = an;
    pad = p;
    led_status = 5'($urandom);
    repeat (10) @(posedge clk_sys);
    #1 rst_b = 1'h1;
    repeat (4) @(posedge clk_sys);
    #1 calc();
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    {rst_b, mf, pad, cfg1st, cfg2nd, fds, led_status} = 19'h00000;
    {mac_tx_en, mac_tx_er, mac_txd} = 6'h00;
    void'($urandom(32'hCC9033C6));
    for (int i = 0; i < 6; i++) begin
      boot(i[0], (i == 0) ? 5'h00 : 5'($urandom));
      rdc(strap_pkg::ADDR_CTRL, xc, "ctrl");
      rdc(strap_pkg::ADDR_ADV, xa, "adv");
      chk("adv_out", {12'h000, xa[8:5]}, {12'h000, adv});
      chk("pins", {4'h0, led_status ^ pad, 5'h1F, pad == 5'h00, 1'h0},
          {4'h0, led_pad_o_q, led_pad_oe_q, iso, crst});
    end
    mdio_master_model_i.xfer(2'h2, pad ^ 5'h01, 5'h00, 16'h0000, rd);
    chk("stray", 16'hFFFF, rd);
    for (int a = 0; a < 4; a++) begin
      v[a] = 16'($urandom);
      wr(5'(strap_pkg::ADDR_CFG_INFO + 5'(a)), v[a]);
      rdc(5'(strap_pkg::ADDR_CFG_INFO + 5'(a)), v[a], "vendor");
    end
    wr(5'h07, 16'hFFFF);
    rdc(5'h07, 16'h0000, "hole");
    wr(strap_pkg::ADDR_CTRL, 16'h4400);
    chk("modes", 16'h0002, {14'h0000, lb, autoneg_enable_bit});
    @(posedge clk_sys) #1 {mac_tx_en, mac_tx_er, mac_txd} = 6'h3F;
    @(posedge clk_sys) #1;
    chk("iso", 16'h0000, {14'h0000, tx_en_q, mii_oe});
    rdc(strap_pkg::ADDR_CTRL, 16'h4400, "ctrl_w");
    wr(strap_pkg::ADDR_CTRL, 16'h2380);
    chk("forced", 16'h001E, {10'h000, 2'(n_rsa), fsp, ffd, col, pdn});
    @(posedge clk_sys) #1 {mac_tx_en, mac_tx_er, mac_txd} = 6'($urandom);
    @(posedge clk_sys) #1;
    chk("tx", {10'h000, mac_tx_en, mac_tx_er, mac_txd},
        {10'h000, tx_en_q, tx_er_q, txd_q});
    {mf, cfg1st, cfg2nd, fds} = 8'($urandom);
    mf[0] = 1'h1;
    rdc(strap_pkg::ADDR_ADV, xa, "adv_hold");
    wr(strap_pkg::ADDR_CTRL, 16'h8000);
    calc();
    rdc(strap_pkg::ADDR_CTRL, xc, "ctrl_sr");
    rdc(strap_pkg::ADDR_ADV, xa, "adv_sr");
    rdc(strap_pkg::ADDR_INT_EN, 16'h0000, "vendor_sr");
    final_report();
  end
endmodule // testbench
